// ### inc/bssfc_pkg.sv
// Constants for the boost sync, spread spectrum and fault supervisor.
// Assumes a 50 MHz core clock; the sync pin is sampled in both the link and the core domain.
package bssfc_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned UV_TIMEOUT_MS = 110;
   localparam int unsigned UV_TIMEOUT_CYC = CLK_HZ / 1000 * UV_TIMEOUT_MS;
   // Slowest valid sync clock is 100 kHz; rising edges over two of its periods apart mean a static level
   localparam int unsigned SYNC_MIN_KHZ = 100;
   localparam int unsigned SYNC_MAX_KHZ = 2222;
   localparam int unsigned SYNC_TMO_CYC = CLK_HZ / 1000 / SYNC_MIN_KHZ * 2;
   localparam int unsigned CODE_W = 12;
   localparam logic [11:0] CODE_FULL = 12'hfff;
   localparam int unsigned CODE_DIV = 4095;
   localparam logic [1:0] SPAN_RST = 2'h2;
   localparam logic [1:0] RATE_RST = 2'h0;
   // Span in tenths of a percent, rate in hertz, indexed by field code
   localparam logic [6:0] SPAN_PERMILLE [4] = '{7'd33, 7'd43, 7'd53, 7'd72};
   localparam logic [10:0] RATE_HZ [4] = '{11'd200, 11'd500, 11'd800, 11'd1200};
   localparam int unsigned SKIP_MAX = 3;
   typedef enum logic [1:0] {BSSFC_RUN, BSSFC_HOLD, BSSFC_RECOVER} bssfc_state_type;
endpackage : bssfc_pkg

// ### hdl/bssfc_core.sv
// Supervisor for a boost converter: clock source, dither, faults, string current.
// Assumes comparator flags on clk_i; sync pin and link clock are asynchronous.
`timescale 1ns/1ps

// Operation
// - An over-voltage-low trip stops the boost switch and sets overvolt_low_flag.
// - During over-voltage-low the sinks stay on and switching resumes once it clears.
// - An over-voltage-high trip enters fault recovery and sets overvolt_high_flag.
// - An under-voltage trip starts a 110 ms timeout counter.
// - If under-voltage persists until expiry, recovery is entered and a flag is set.
// - A static high sync pin enables spread spectrum and a static low disables it.
// - A 100 kHz to 2222 kHz clock on the sync pin synchronises boost switching.
// - While synchronised to an external clock spread spectrum is off.
// - When the sync clock stops, the resistor frequency runs and the last level rules.
// - The span field picks 3.3, 4.3, 5.3 (reset) or 7.2 percent deviation.
// - The rate field picks 200 (reset), 500, 800 or 1200 Hz modulation.
// - Under light load switching cycles are skipped intermittently.
// - Each string current is full scale times its code over 4095.
// - Every string code resets to full scale.
module bssfc_core #(
   parameter int unsigned STRINGS = 6,
   parameter int unsigned UV_CYC = bssfc_pkg::UV_TIMEOUT_CYC,
   parameter int unsigned SYNC_CYC = bssfc_pkg::SYNC_TMO_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic link_clk_i,
   input wire logic converter_clock_select_pin_i,
   input wire logic ovp_low_cmp_i,
   input wire logic ovp_high_cmp_i,
   input wire logic uvp_cmp_i,
   input wire logic light_load_i,
   input wire logic recover_done_i,
   input wire logic flag_clear_i,
   input wire logic [1:0] dither_span_select_i,
   input wire logic [1:0] dither_rate_select_i,
   input wire logic dither_wr_i,
   input wire logic [bssfc_pkg::CODE_W-1:0] string_current_code_i,
   input wire logic [$clog2(STRINGS)-1:0] string_sel_i,
   input wire logic string_wr_i,
   output logic switch_en_o,
   output logic sinks_en_o,
   output logic recovery_o,
   output logic overvolt_low_flag_o,
   output logic overvolt_high_flag_o,
   output logic undervolt_timeout_flag_o,
   output logic ext_sync_o,
   output logic spread_en_o,
   output logic [1:0] dither_span_field_o,
   output logic [1:0] dither_rate_field_o,
   output logic [6:0] span_permille_o,
   output logic [10:0] rate_hz_o,
   output logic [STRINGS*bssfc_pkg::CODE_W-1:0] string_current_code_o,
   output logic [STRINGS*bssfc_pkg::CODE_W-1:0] string_scale_o
);
   import bssfc_pkg::*;

   localparam int UVW = $clog2(UV_CYC + 1);
   localparam int SYW = $clog2(SYNC_CYC + 1);

   // Reset brought into the link domain through two flip-flops
   logic lk_rst_m_q, lk_rst_s_q;
   always_ff @(posedge link_clk_i) begin
      lk_rst_m_q <= rst_i;
      lk_rst_s_q <= lk_rst_m_q;
   end

   // Link domain: each rising pin edge flips a toggle that crosses to the core
   logic lk_m_q, lk_s_q, lk_p_q, lk_tog_q;
   always_ff @(posedge link_clk_i) begin
      lk_m_q <= converter_clock_select_pin_i;
      lk_s_q <= lk_m_q;
      lk_p_q <= lk_s_q;
   end

   always_ff @(posedge link_clk_i) begin
      if (lk_rst_s_q) begin
         lk_tog_q <= 1'b0;
      end else if (lk_s_q && !lk_p_q) begin
         lk_tog_q <= ~lk_tog_q;
      end
   end

   // Core domain pin level synchroniser
   logic pin_m_q, pin_s_q;
   always_ff @(posedge clk_i) begin
      pin_m_q <= converter_clock_select_pin_i;
      pin_s_q <= pin_m_q;
   end

   // Toggle synchroniser starts equal so reset release shows no false edge
   logic tog_m_q, tog_s_q, tog_p_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tog_m_q <= 1'b0;
         tog_s_q <= 1'b0;
         tog_p_q <= 1'b0;
      end else begin
         tog_m_q <= lk_tog_q;
         tog_s_q <= tog_m_q;
         tog_p_q <= tog_s_q;
      end
   end

   // Only the toggle counts: a single static step must give a single edge
   logic pin_edge;
   assign pin_edge = (tog_s_q != tog_p_q);

   // Edge watchdog decides between clock and static level
   logic [SYW-1:0] sync_cnt_q;
   logic ext_sync_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_cnt_q <= '0;
         ext_sync_q <= 1'b0;
      end else if (pin_edge) begin
         sync_cnt_q <= SYW'(SYNC_CYC);
         ext_sync_q <= (sync_cnt_q != '0);
      end else if (sync_cnt_q != '0) begin
         sync_cnt_q <= sync_cnt_q - 1'b1;
      end else begin
         ext_sync_q <= 1'b0;
      end
   end
   assign ext_sync_o = ext_sync_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spread_en_o <= 1'b0;
      end else begin
         spread_en_o <= !ext_sync_q && pin_s_q;
      end
   end

   // Dither settings
   logic [1:0] span_q, rate_q;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         span_q <= SPAN_RST;
         rate_q <= RATE_RST;
      end else if (dither_wr_i) begin
         span_q <= dither_span_select_i;
         rate_q <= dither_rate_select_i;
      end
   end
   assign dither_span_field_o = span_q;
   assign dither_rate_field_o = rate_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         span_permille_o <= SPAN_PERMILLE[SPAN_RST];
         rate_hz_o <= RATE_HZ[RATE_RST];
      end else begin
         span_permille_o <= SPAN_PERMILLE[span_q];
         rate_hz_o <= RATE_HZ[rate_q];
      end
   end

   // Fault state machine
   bssfc_state_type state_q;
   logic [UVW-1:0] uv_cnt_q;
   logic uv_expire;
   assign uv_expire = uvp_cmp_i && (uv_cnt_q == UVW'(UV_CYC - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i || !uvp_cmp_i || state_q == BSSFC_RECOVER) begin
         uv_cnt_q <= '0;
      end else begin
         uv_cnt_q <= uv_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= BSSFC_RUN;
      end else begin
         case (state_q)
            BSSFC_RUN, BSSFC_HOLD: begin
               if (ovp_high_cmp_i || uv_expire) begin
                  state_q <= BSSFC_RECOVER;
               end else if (ovp_low_cmp_i) begin
                  state_q <= BSSFC_HOLD;
               end else begin
                  state_q <= BSSFC_RUN;
               end
            end
            BSSFC_RECOVER: begin
               if (recover_done_i && !ovp_high_cmp_i) begin
                  state_q <= BSSFC_RUN;
               end
            end
            default: state_q <= BSSFC_RUN;
         endcase
      end
   end

   // Sticky flags: a new event wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overvolt_low_flag_o <= 1'b0;
         overvolt_high_flag_o <= 1'b0;
         undervolt_timeout_flag_o <= 1'b0;
      end else begin
         overvolt_low_flag_o <= ovp_low_cmp_i || (overvolt_low_flag_o && !flag_clear_i);
         overvolt_high_flag_o <= ovp_high_cmp_i ||
            (overvolt_high_flag_o && !flag_clear_i);
         undervolt_timeout_flag_o <= uv_expire ||
            (undervolt_timeout_flag_o && !flag_clear_i);
      end
   end

   // Light load skipping: drop a switch cycle out of every few
   logic [1:0] skip_q;
   always_ff @(posedge clk_i) begin
      if (rst_i || !light_load_i) begin
         skip_q <= '0;
      end else begin
         skip_q <= (skip_q == 2'(SKIP_MAX)) ? 2'h0 : skip_q + 2'h1;
      end
   end

   logic fault_next;
   assign fault_next = ovp_high_cmp_i || uv_expire || ovp_low_cmp_i;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         switch_en_o <= 1'b0;
         sinks_en_o <= 1'b0;
         recovery_o <= 1'b0;
      end else begin
         switch_en_o <= (state_q != BSSFC_RECOVER) && !fault_next &&
            !(light_load_i && skip_q == 2'(SKIP_MAX));
         sinks_en_o <= (state_q != BSSFC_RECOVER) &&
            !(ovp_high_cmp_i || uv_expire);
         recovery_o <= (state_q == BSSFC_RECOVER) || ovp_high_cmp_i || uv_expire;
      end
   end

   // Per-string current codes and scale (code * 4095 / 4095 in Q12 of full scale)
   genvar g;
   generate
      for (g = 0; g < STRINGS; g++) begin : g_str
         logic [CODE_W-1:0] code_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               code_q <= CODE_FULL;
            end else if (string_wr_i && string_sel_i == ($clog2(STRINGS))'(g)) begin
               code_q <= string_current_code_i;
            end
         end
         logic [CODE_W-1:0] scale_q;
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               scale_q <= CODE_FULL;
            end else begin
               scale_q <= CODE_W'((24'(code_q) * 24'(CODE_FULL)) / 24'(CODE_DIV));
            end
         end
         assign string_current_code_o[g*CODE_W +: CODE_W] = code_q;
         assign string_scale_o[g*CODE_W +: CODE_W] = scale_q;
      end
   endgenerate

   // Checks
   property p_ovpl_stop;
      @(posedge clk_i) disable iff (rst_i)
      ovp_low_cmp_i |=> !switch_en_o && overvolt_low_flag_o;
   endproperty
   a_ovpl_stop: assert property (p_ovpl_stop) else $error("switch on during ovp low");

   property p_ovpl_sinks;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == BSSFC_HOLD && ovp_low_cmp_i && !ovp_high_cmp_i && !uv_expire) |=> sinks_en_o;
   endproperty
   a_ovpl_sinks: assert property (p_ovpl_sinks) else $error("sinks off in ovp low");

   property p_ovph;
      @(posedge clk_i) disable iff (rst_i)
      ovp_high_cmp_i |=> recovery_o && overvolt_high_flag_o && state_q == BSSFC_RECOVER;
   endproperty
   a_ovph: assert property (p_ovph) else $error("ovp high not handled");

   property p_uv_count;
      @(posedge clk_i) disable iff (rst_i)
      (uvp_cmp_i && state_q != BSSFC_RECOVER && !uv_expire) |=> uv_cnt_q == $past(uv_cnt_q) + 1'b1;
   endproperty
   a_uv_count: assert property (p_uv_count) else $error("uv counter stalled");

   property p_uv_fault;
      @(posedge clk_i) disable iff (rst_i)
      uv_expire |=> undervolt_timeout_flag_o && recovery_o;
   endproperty
   a_uv_fault: assert property (p_uv_fault) else $error("uv timeout missed");

   property p_uv_clear;
      @(posedge clk_i) disable iff (rst_i)
      !uvp_cmp_i |=> uv_cnt_q == '0;
   endproperty
   a_uv_clear: assert property (p_uv_clear) else $error("uv counter kept");

   property p_sync_nospread;
      @(posedge clk_i) disable iff (rst_i)
      ext_sync_q |=> !spread_en_o;
   endproperty
   a_sync_nospread: assert property (p_sync_nospread) else $error("spread during sync");

   property p_static_level;
      @(posedge clk_i) disable iff (rst_i)
      (!ext_sync_q && $stable(pin_s_q)) |=> spread_en_o == $past(pin_s_q);
   endproperty
   a_static_level: assert property (p_static_level) else $error("spread vs pin");

   property p_code_reset;
      @(posedge clk_i) $fell(rst_i) |-> string_current_code_o == {STRINGS{CODE_FULL}};
   endproperty
   a_code_reset: assert property (p_code_reset) else $error("codes not full scale");

   property p_ovpl_resume;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == BSSFC_HOLD && !fault_next && !light_load_i) |=> switch_en_o;
   endproperty
   a_ovpl_resume: assert property (p_ovpl_resume) else $error("no resume");

   property p_rec_hold;
      @(posedge clk_i) disable iff (rst_i)
      (state_q == BSSFC_RECOVER && (!recover_done_i || ovp_high_cmp_i)) |=>
         state_q == BSSFC_RECOVER && recovery_o;
   endproperty
   a_rec_hold: assert property (p_rec_hold) else $error("recovery left early");

   property p_uv_silent;
      @(posedge clk_i) disable iff (rst_i)
      (!uvp_cmp_i && !undervolt_timeout_flag_o) |=> !undervolt_timeout_flag_o;
   endproperty
   a_uv_silent: assert property (p_uv_silent) else $error("uv flag without uv");

   property p_sync_lock;
      @(posedge clk_i) disable iff (rst_i)
      (pin_edge && sync_cnt_q != '0) |=> ext_sync_q;
   endproperty
   a_sync_lock: assert property (p_sync_lock) else $error("sync not detected");

   property p_sync_drop;
      @(posedge clk_i) disable iff (rst_i)
      (!pin_edge && sync_cnt_q == '0) |=> !ext_sync_q;
   endproperty
   a_sync_drop: assert property (p_sync_drop) else $error("sync kept");

   property p_dither_reset;
      @(posedge clk_i) $fell(rst_i) |->
         dither_span_field_o == SPAN_RST && dither_rate_field_o == RATE_RST &&
         span_permille_o == SPAN_PERMILLE[SPAN_RST] && rate_hz_o == RATE_HZ[RATE_RST];
   endproperty
   a_dither_reset: assert property (p_dither_reset) else $error("dither reset");

   property p_skip;
      @(posedge clk_i) disable iff (rst_i)
      (light_load_i && skip_q == 2'(SKIP_MAX)) |=> !switch_en_o;
   endproperty
   a_skip: assert property (p_skip) else $error("skip cycle switched");
endmodule : bssfc_core

// ### bench/bssfc_sync_src.sv
// Model of the sync pin driver: a static level, or a free clock while run_i is high.
// Assumes the bench sets level_i before it stops the clock.
`timescale 1ns/1ps
module bssfc_sync_src #(
   parameter int HALF_NS = 250
) (
   input wire logic run_i,
   input wire logic level_i,
   output logic pin_o
);
   initial begin
      pin_o = 1'b0;
      forever begin
         if (run_i) begin
            #(HALF_NS) pin_o = ~pin_o;
         end else begin
            pin_o = level_i;
            @(run_i or level_i);
         end
      end
   end
endmodule : bssfc_sync_src

// ### bench/bssfc_core_tb.sv
// Bench for the boost supervisor: faults, sync pin, dither fields, string codes.
// Assumes short timeout parameters; the sync pin comes from the partner model.
`timescale 1ns/1ps
module bssfc_core_tb;
   import bssfc_pkg::*;
   localparam int UV = 50;
   localparam logic [11:0] SP_E [4] = '{12'h021, 12'h02b, 12'h035, 12'h048};
   localparam logic [11:0] RT_E [4] = '{12'h0c8, 12'h1f4, 12'h320, 12'h4b0};
   logic clk_i, rst_i, link_clk_i, ovl, ovh, uvp, ll, rdone, fclr, dwr, swr;
   logic sw_en, snk_en, rec, fl_l, fl_h, fl_u, ext, spr, run, lvl, pin;
   logic [1:0] span, rate, span_f, rate_f;
   logic [11:0] code;
   logic [2:0] sel;
   logic [6:0] pm;
   logic [10:0] hz;
   logic [71:0] codes, scales;
   int n_errors = 0;
   int tests_run = 0;

   bssfc_core #(.STRINGS(6), .UV_CYC(UV), .SYNC_CYC(40)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
      .converter_clock_select_pin_i(pin), .ovp_low_cmp_i(ovl), .ovp_high_cmp_i(ovh),
      .uvp_cmp_i(uvp), .light_load_i(ll), .recover_done_i(rdone), .flag_clear_i(fclr),
      .dither_span_select_i(span), .dither_rate_select_i(rate), .dither_wr_i(dwr),
      .string_current_code_i(code), .string_sel_i(sel), .string_wr_i(swr),
      .switch_en_o(sw_en), .sinks_en_o(snk_en), .recovery_o(rec),
      .overvolt_low_flag_o(fl_l), .overvolt_high_flag_o(fl_h),
      .undervolt_timeout_flag_o(fl_u), .ext_sync_o(ext), .spread_en_o(spr),
      .dither_span_field_o(span_f), .dither_rate_field_o(rate_f),
      .span_permille_o(pm), .rate_hz_o(hz),
      .string_current_code_o(codes), .string_scale_o(scales)
   );
   bssfc_sync_src i_src (.run_i(run), .level_i(lvl), .pin_o(pin));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #7;
      forever #15 link_clk_i = ~link_clk_i;
   end

   task cy(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : cy
   task chk(input logic [11:0] got, input logic [11:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task end_sim;
      $display("Checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   task recover;
      rdone = 1'b1;
      cy(1);
      rdone = 1'b0;
      fclr = 1'b1;
      cy(1);
      fclr = 1'b0;
      cy(3);
   endtask : recover

   task t_ovl;
      ovl = 1'b1;
      cy(2);
      chk(sw_en, 1'b0);
      chk(fl_l, 1'b1);
      chk(snk_en, 1'b1);
      ovl = 1'b0;
      cy(3);
      chk(sw_en, 1'b1);
      recover();
   endtask : t_ovl
   task t_ovh;
      ovh = 1'b1;
      cy(2);
      chk(rec, 1'b1);
      chk(fl_h, 1'b1);
      ovh = 1'b0;
      recover();
      chk(rec, 1'b0);
      chk(fl_h, 1'b0);
   endtask : t_ovh
   task t_uv;
      uvp = 1'b1;
      cy(40);
      uvp = 1'b0;
      cy(2);
      chk(fl_u, 1'b0);
      chk(rec, 1'b0);
      uvp = 1'b1;
      cy(UV - 1);
      chk(fl_u, 1'b0);
      cy(1);
      chk(fl_u, 1'b1);
      chk(rec, 1'b1);
      uvp = 1'b0;
      recover();
   endtask : t_uv
   task t_dith;
      chk(span_f, 2'h2);
      chk(rate_f, 2'h0);
      for (int i = 0; i < 4; i++) begin
         span = 2'(i);
         rate = 2'(3 - i);
         dwr = 1'b1;
         cy(1);
         dwr = 1'b0;
         cy(3);
         chk(span_f, span);
         chk(pm, SP_E[i]);
         chk(rate_f, rate);
         chk(hz, RT_E[3 - i]);
      end
   endtask : t_dith
   task t_sync;
      lvl = 1'b1;
      cy(10);
      chk(spr, 1'b1);
      lvl = 1'b0;
      cy(10);
      chk(spr, 1'b0);
      lvl = 1'b1;
      run = 1'b1;
      cy(60);
      chk(ext, 1'b1);
      chk(spr, 1'b0);
      run = 1'b0;
      cy(80);
      chk(ext, 1'b0);
      chk(spr, 1'b1);
   endtask : t_sync
   task t_str;
      chk(codes[35:24], 12'hfff);
      swr = 1'b1;
      sel = 3'h0;
      code = 12'h000;
      cy(1);
      sel = 3'h5;
      code = 12'h800;
      cy(1);
      sel = 3'h7;
      code = 12'h123;
      cy(1);
      swr = 1'b0;
      cy(3);
      chk(scales[11:0], 12'h000);
      chk(codes[71:60], 12'h800);
      chk(codes[11:0], 12'h000);
      chk(scales[71:60], 12'h800);
      chk(scales[35:24], 12'hfff);
   endtask : t_str
   task t_light;
      int k;
      k = 0;
      ll = 1'b1;
      cy(4);
      repeat (16) begin
         if (sw_en !== 1'b1) k++;
         cy(1);
      end
      ll = 1'b0;
      chk(12'(k), 12'h004);
   endtask : t_light

   initial begin
      {ovl, ovh, uvp, ll, rdone, fclr, dwr, swr, run, lvl} = '0;
      span = 2'h0;
      rate = 2'h0;
      code = 12'h000;
      sel = 3'h0;
      rst_i = 1'b1;
      cy(4);
      rst_i = 1'b0;
      cy(3);
      t_str();
      t_dith();
      t_ovl();
      t_ovh();
      t_uv();
      t_sync();
      t_light();
      end_sim();
   end
   // The whole sequence needs well under 2000 clock cycles
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
endmodule : bssfc_core_tb
